// ### design/cssc_pkg.sv
// Shared constants and types for the clock source and start-up control block
package cssc_pkg;

  // Fuse polarity
  localparam logic FUSE_PROGRAMMED = 1'b0;

  // Clock source select codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_RC_LOW = 2'h1;
  localparam logic [1:0] SRC_RC_HIGH = 2'h2;
  localparam logic [1:0] SRC_LF = 2'h3;

  // Start-up delay codes
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_RSVD = 2'h3;

  // Start-up counts in selected-source cycles
  localparam int PD_START_CK = 6;
  localparam int RST_START_CK = 14;

  // Reset time-out in milliseconds and in watchdog oscillator cycles
  localparam int WDT_SHORT_MS = 4;
  localparam int WDT_LONG_MS = 64;
  localparam int WDT_SHORT_CYC = 512;
  localparam int WDT_LONG_CYC = 8192;
  localparam int CNT_W = 14;

  // Prescaler select values
  localparam logic [3:0] PRESC_DIV8_RST = 4'h3;
  localparam logic [3:0] PRESC_DIV1_RST = 4'h0;
  localparam logic [3:0] PRESC_MAX = 4'h8;
  localparam int PRESC_CNT_W = 8;

  // Oscillator trim register
  localparam int TRIM_W = 7;
  localparam int TRIM_RSVD_BIT = 7;

  // Synchronised pin positions
  localparam int PIN_EXT = 0;
  localparam int PIN_RC = 1;
  localparam int PIN_LF = 2;
  localparam int PIN_WDT = 3;
  localparam int PIN_INT = 4;
  localparam int NPIN = 5;

  typedef enum logic [1:0] {ST_SRC, ST_WDT, ST_RUN, ST_DOWN} cssc_state_t;

endpackage

// ### design/cssc_tick_counter.sv
// Loadable down-counter that advances on a tick and flags completion
`timescale 1ns/1ps
module cssc_tick_counter #(
  parameter int W = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_value_i,
  input wire logic tick_i,
  output logic done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } cssc_cnt_state_t;

  cssc_cnt_state_t st_r;
  cssc_cnt_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load_i) begin
      st_nxt.cnt = load_value_i;
      st_nxt.done = (load_value_i == '0);
    end else if (tick_i && st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
      st_nxt.done = (st_r.cnt == W'(1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_o = st_r.done;

  a_load_not_done: assert property (@(posedge clk_i) disable iff (rst_i)
    load_i && load_value_i != '0 |=> !done_o) else $error("counter done right after load");

endmodule // cssc_tick_counter

// ### design/cssc_prescaler.sv
// System clock prescaler producing one tick per 2^select source ticks
`timescale 1ns/1ps
module cssc_prescaler
  import cssc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic src_tick_i,
  input wire logic [3:0] select_i,
  output logic sys_tick_o
);

  typedef struct packed {
    logic [PRESC_CNT_W-1:0] cnt;
    logic tick;
  } cssc_presc_state_t;

  cssc_presc_state_t st_r;
  cssc_presc_state_t st_nxt;

  // Reserved codes fall back to the largest division
  function automatic logic [PRESC_CNT_W-1:0] cssc_div_mask(input logic [3:0] sel);
    logic [3:0] s;
    logic [PRESC_CNT_W:0] one_hot;
    s = (sel > PRESC_MAX) ? PRESC_MAX : sel;
    one_hot = (PRESC_CNT_W+1)'(1) << s;
    return PRESC_CNT_W'(one_hot - 1'b1);
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (src_tick_i) begin
      if ((st_r.cnt & cssc_div_mask(select_i)) == cssc_div_mask(select_i)) begin
        st_nxt.tick = 1'b1;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sys_tick_o = st_r.tick;

  a_div1_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    src_tick_i && select_i == PRESC_DIV1_RST |=> sys_tick_o) else $error("undivided tick lost");

endmodule // cssc_prescaler

// ### design/clock_source_startup_control.sv
// Clock source selection, start-up sequencing, trim register and clock domain enables
`timescale 1ns/1ps

// What this block does
// - Core clock enable drops whenever the core is halted, stopping all core state.
// - Certain external interrupt pins are detected even with peripheral clock halted.
// - Program-memory clock enable runs together with the core clock enable.
// - Converter clock has its own enable, running while core and peripheral halt.
// - Fuse value 1 means unprogrammed, 0 means programmed.
// - Source codes 10 and 01 select the internal RC oscillator, fast or slow.
// - Source code 00 selects the external clock input pin.
// - Source code 11 selects the 128 kHz low-power oscillator.
// - After power-down wake, count start-up cycles of the selected source first.
// - After reset, add 512 or 8192 watchdog oscillator cycles as configured.
// - Six cycles from power-down; fourteen from reset plus none, 4 ms or 64 ms.
// - Shipped defaults: RC source 10, start-up 10, divide-by-eight programmed.
// - Programmed divide-by-eight divides the oscillator by 8 at start-up.
// - Reset loads the factory calibration byte into the trim register.
// - Watchdog and reset time-out always run from the watchdog oscillator.
// - Bit 7 of the trim register always reads zero.
// - Trim zero gives lowest frequency, rising with value, highest at 0x7F.
// - The calibrated RC oscillator times nonvolatile memory writes.
// - Reset sets prescaler select to 0011 if divide-by-eight programmed, else 0000.
module clock_source_startup_control
  import cssc_pkg::*;
#(
  parameter int WDT_SHORT_CYCLES = WDT_SHORT_CYC,
  parameter int WDT_LONG_CYCLES = WDT_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] clock_source_select_fuse_i,
  input wire logic [1:0] startup_delay_fuse_i,
  input wire logic divide_by_eight_fuse_i,
  input wire logic [7:0] factory_calibration_i,
  input wire logic external_clock_input_i,
  input wire logic rc_osc_i,
  input wire logic lf_osc_i,
  input wire logic wdt_osc_i,
  input wire logic ext_int_pin_i,
  input wire logic powerdown_i,
  input wire logic wake_i,
  input wire logic core_halt_i,
  input wire logic peripheral_halt_i,
  input wire logic trim_wr_i,
  input wire logic [7:0] trim_wdata_i,
  input wire logic prescaler_wr_i,
  input wire logic [3:0] prescaler_wdata_i,
  output logic [7:0] trim_rdata_o,
  output logic [6:0] trim_value_o,
  output logic [3:0] prescaler_select_o,
  output logic rc_high_range_o,
  output logic system_tick_o,
  output logic watchdog_tick_o,
  output logic nvm_timing_tick_o,
  output logic ext_int_detect_o,
  output logic exec_release_o,
  output logic core_clock_en_o,
  output logic peripheral_clock_en_o,
  output logic program_memory_clock_en_o,
  output logic converter_clock_en_o
);

  typedef struct packed {
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [1:0] src_sel;
    logic [1:0] startup_delay_fuse;
    logic div8;
    logic [TRIM_W-1:0] trim;
    logic [3:0] presc;
    cssc_state_t state;
    logic load_req;
    logic from_reset;
    logic release_q;
    logic core_en;
    logic peri_en;
    logic flash_en;
    logic conv_en;
    logic wdt_tick;
    logic nvm_tick;
    logic int_det;
    logic rc_high;
  } cssc_state_s_t;

  cssc_state_s_t st_r;
  cssc_state_s_t st_nxt;

  logic [NPIN-1:0] edge_w;
  logic src_tick;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_tick;
  logic cnt_done;

  function automatic logic [CNT_W-1:0] cssc_wdt_cycles(input logic [1:0] startup_delay_fuse);
    case (startup_delay_fuse)
      SUT_NONE: return '0;
      SUT_SHORT: return CNT_W'(WDT_SHORT_CYCLES);
      default: return CNT_W'(WDT_LONG_CYCLES);
    endcase
  endfunction

  function automatic logic cssc_is_rc(input logic [1:0] sel);
    return (sel == SRC_RC_LOW) || (sel == SRC_RC_HIGH);
  endfunction

  assign edge_w = st_r.sync2 & ~st_r.sync3;

  // Source multiplexer
  always_comb begin
    case (st_r.src_sel)
      SRC_EXT: src_tick = edge_w[PIN_EXT];
      SRC_LF: src_tick = edge_w[PIN_LF];
      default: src_tick = edge_w[PIN_RC];
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    cnt_load = 1'b0;
    cnt_value = '0;
    cnt_tick = 1'b0;
    st_nxt.sync1 = {ext_int_pin_i, wdt_osc_i, lf_osc_i, rc_osc_i, external_clock_input_i};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    if (trim_wr_i) begin
      st_nxt.trim = trim_wdata_i[TRIM_W-1:0];
    end
    if (prescaler_wr_i) begin
      st_nxt.presc = prescaler_wdata_i;
    end
    case (st_r.state)
      ST_SRC: begin
        cnt_tick = src_tick;
        if (st_r.load_req) begin
          cnt_load = 1'b1;
          cnt_value = st_r.from_reset ? CNT_W'(RST_START_CK) : CNT_W'(PD_START_CK);
          st_nxt.load_req = 1'b0;
        end else if (cnt_done) begin
          st_nxt.state = st_r.from_reset ? ST_WDT : ST_RUN;
          st_nxt.load_req = st_r.from_reset;
        end
      end
      ST_WDT: begin
        cnt_tick = edge_w[PIN_WDT];
        if (st_r.load_req) begin
          cnt_load = 1'b1;
          cnt_value = cssc_wdt_cycles(st_r.startup_delay_fuse);
          st_nxt.load_req = 1'b0;
        end else if (cnt_done) begin
          st_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (powerdown_i) begin
          st_nxt.state = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (wake_i) begin
          st_nxt.state = ST_SRC;
          st_nxt.load_req = 1'b1;
          st_nxt.from_reset = 1'b0;
        end
      end
      default: begin
        st_nxt.state = ST_SRC;
        st_nxt.load_req = 1'b1;
      end
    endcase
    st_nxt.release_q = (st_nxt.state == ST_RUN);
    st_nxt.core_en = st_nxt.release_q && !core_halt_i;
    st_nxt.flash_en = st_nxt.core_en;
    st_nxt.peri_en = st_nxt.release_q && !peripheral_halt_i;
    st_nxt.conv_en = st_nxt.release_q;
    st_nxt.wdt_tick = edge_w[PIN_WDT];
    st_nxt.nvm_tick = edge_w[PIN_RC];
    st_nxt.int_det = st_r.sync2[PIN_INT];
    st_nxt.rc_high = (st_r.src_sel == SRC_RC_HIGH) && cssc_is_rc(st_r.src_sel);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      // Synchronisers keep running so no false edge follows reset
      st_r.sync1 <= st_nxt.sync1;
      st_r.sync2 <= st_nxt.sync2;
      st_r.sync3 <= st_nxt.sync3;
      // Fuses and calibration are sampled while reset is held
      st_r.src_sel <= clock_source_select_fuse_i;
      st_r.startup_delay_fuse <= startup_delay_fuse_i;
      st_r.div8 <= divide_by_eight_fuse_i;
      st_r.trim <= factory_calibration_i[TRIM_W-1:0];
      st_r.presc <= (divide_by_eight_fuse_i == FUSE_PROGRAMMED) ?
                    PRESC_DIV8_RST : PRESC_DIV1_RST;
      st_r.state <= ST_SRC;
      st_r.load_req <= 1'b1;
      st_r.from_reset <= 1'b1;
      st_r.rc_high <= (clock_source_select_fuse_i == SRC_RC_HIGH);
    end else begin
      st_r <= st_nxt;
    end
  end

  cssc_tick_counter #(
    .W(CNT_W)
  ) u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(cnt_load),
    .load_value_i(cnt_value),
    .tick_i(cnt_tick),
    .done_o(cnt_done)
  );

  // Divide-by-eight start-up comes from the prescaler reset value
  cssc_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_tick_i(src_tick),
    .select_i(st_r.presc),
    .sys_tick_o(system_tick_o)
  );

  assign trim_rdata_o = {1'b0, st_r.trim};
  assign trim_value_o = st_r.trim;
  assign prescaler_select_o = st_r.presc;
  assign rc_high_range_o = st_r.rc_high;
  assign watchdog_tick_o = st_r.wdt_tick;
  assign nvm_timing_tick_o = st_r.nvm_tick;
  assign ext_int_detect_o = st_r.int_det;
  assign exec_release_o = st_r.release_q;
  assign core_clock_en_o = st_r.core_en;
  assign peripheral_clock_en_o = st_r.peri_en;
  assign program_memory_clock_en_o = st_r.flash_en;
  assign converter_clock_en_o = st_r.conv_en;

  // Helper counts of ticks seen in each start-up phase
  int src_seen;
  int wdt_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i || st_r.load_req) begin
      src_seen <= 0;
      wdt_seen <= (st_r.state == ST_SRC) ? 0 : wdt_seen;
      if (rst_i) begin
        wdt_seen <= 0;
      end
    end else begin
      if (st_r.state == ST_SRC && !cnt_done && src_tick) begin
        src_seen <= src_seen + 1;
      end
      if (st_r.state == ST_WDT && !cnt_done && edge_w[PIN_WDT]) begin
        wdt_seen <= wdt_seen + 1;
      end
    end
  end

  sequence s_src_end;
    st_r.state == ST_SRC && !st_r.load_req && cnt_done;
  endsequence

  sequence s_release_from_reset;
    $rose(exec_release_o) && st_r.from_reset;
  endsequence

  a_core_halt_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    core_halt_i |=> !core_clock_en_o) else $error("core clock ran while halted");
  a_int_in_down: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.state == ST_DOWN && st_r.sync2[PIN_INT] |=> ext_int_detect_o)
    else $error("interrupt missed in power-down");
  a_flash_follows_core: assert property (@(posedge clk_i) disable iff (rst_i)
    program_memory_clock_en_o == core_clock_en_o) else $error("flash clock differs from core");
  a_conv_runs_alone: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.state == ST_RUN && !powerdown_i && core_halt_i && peripheral_halt_i
    |=> converter_clock_en_o && !core_clock_en_o && !peripheral_clock_en_o)
    else $error("converter clock stopped with core");
  a_src_ext_mux: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.src_sel == SRC_EXT |-> src_tick == edge_w[PIN_EXT]) else $error("external source not used");
  a_src_rc_mux: assert property (@(posedge clk_i) disable iff (rst_i)
    cssc_is_rc(st_r.src_sel) |-> src_tick == edge_w[PIN_RC]) else $error("RC source not used");
  a_src_lf_mux: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.src_sel == SRC_LF |-> src_tick == edge_w[PIN_LF]) else $error("LF source not used");
  a_src_count: assert property (@(posedge clk_i) disable iff (rst_i)
    s_src_end |-> src_seen == (st_r.from_reset ? RST_START_CK : PD_START_CK))
    else $error("wrong source cycle count");
  a_wdt_count: assert property (@(posedge clk_i) disable iff (rst_i)
    s_release_from_reset |-> wdt_seen == int'(cssc_wdt_cycles(st_r.startup_delay_fuse)))
    else $error("wrong watchdog time-out");
  a_release_state: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(exec_release_o) |-> $past(st_r.state) != ST_DOWN && !st_r.load_req)
    else $error("release before start-up finished");
  a_wdt_tick_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_w[PIN_WDT] |=> watchdog_tick_o) else $error("watchdog tick lost");
  a_nvm_tick_rc: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_w[PIN_RC] |=> nvm_timing_tick_o) else $error("memory timing tick lost");
  a_trim_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    trim_rdata_o[TRIM_RSVD_BIT] == 1'b0) else $error("trim bit 7 not zero");
  a_trim_reset_load: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> trim_value_o == $past(factory_calibration_i[6:0]))
    else $error("calibration byte not loaded");
  a_trim_write: assert property (@(posedge clk_i) disable iff (rst_i)
    trim_wr_i |=> trim_value_o == $past(trim_wdata_i[6:0])) else $error("trim write lost");
  a_presc_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> prescaler_select_o ==
      ((st_r.div8 == FUSE_PROGRAMMED) ? PRESC_DIV8_RST : PRESC_DIV1_RST))
    else $error("prescaler reset value wrong");

endmodule // clock_source_startup_control

// ### dv/cssc_ext_clk_src.sv
// Behavioural external clock source driving the clock input pin
`timescale 1ns/1ps
module cssc_ext_clk_src #(
  parameter int HALF = 4
) (
  input wire logic clk_i,
  input wire logic run_i,
  output logic pin_o
);
  int cnt = 0;
  initial pin_o = 1'b0;
  // Fixed period; only started or stopped while the device sits in reset
  always @(negedge clk_i) begin
    if (!run_i) begin
      cnt <= 0;
      pin_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin_o <= ~pin_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // cssc_ext_clk_src

// ### dv/clock_source_startup_control_tb_top.sv
// Self-checking bench for the clock source and start-up control block
`timescale 1ns/1ps
module clock_source_startup_control_tb_top;
  import cssc_pkg::*;
  localparam int WS = 8;
  localparam int WL = 16;
  logic clk_i = 1'b0, rst_i = 1'b1, div8 = 1'b0, ext, rc = 1'b0, lf = 1'b0, wdt = 1'b0;
  logic [1:0] src = 2'h2, startup_delay_fuse = 2'h2;
  logic [7:0] cal = 8'h00, twd = 8'h00;
  logic [3:0] pwd = 4'h0;
  logic ext_run = 1'b0, rc_run = 1'b0, lf_run = 1'b0, irq = 1'b0, pd = 1'b0, wake = 1'b0;
  logic chalt = 1'b0, phalt = 1'b0, twr = 1'b0, pwr = 1'b0, sel_pin;
  logic [7:0] trd;
  logic [6:0] tval;
  logic [3:0] psel;
  logic rch, stk, wtk, ntk, eid, rel, cen, pen, fen, aen;
  int ph = 0, cyc = 0, n_sel = 0, n_wl = 0, n_sys = 0, n_nvm = 0, n_wtk = 0;
  int miscompares = 0, comparisons = 0;

  always #10 clk_i = ~clk_i;

  clock_source_startup_control #(.WDT_SHORT_CYCLES(WS), .WDT_LONG_CYCLES(WL))
    clock_source_startup_control_inst (
    .clk_i(clk_i), .rst_i(rst_i), .clock_source_select_fuse_i(src),
    .startup_delay_fuse_i(startup_delay_fuse), .divide_by_eight_fuse_i(div8), .factory_calibration_i(cal),
    .external_clock_input_i(ext), .rc_osc_i(rc), .lf_osc_i(lf), .wdt_osc_i(wdt),
    .ext_int_pin_i(irq), .powerdown_i(pd), .wake_i(wake), .core_halt_i(chalt),
    .peripheral_halt_i(phalt), .trim_wr_i(twr), .trim_wdata_i(twd), .prescaler_wr_i(pwr),
    .prescaler_wdata_i(pwd), .trim_rdata_o(trd), .trim_value_o(tval),
    .prescaler_select_o(psel), .rc_high_range_o(rch), .system_tick_o(stk),
    .watchdog_tick_o(wtk), .nvm_timing_tick_o(ntk), .ext_int_detect_o(eid),
    .exec_release_o(rel), .core_clock_en_o(cen), .peripheral_clock_en_o(pen),
    .program_memory_clock_en_o(fen), .converter_clock_en_o(aen));

  cssc_ext_clk_src #(.HALF(4)) cssc_ext_clk_src_inst (.clk_i(clk_i), .run_i(ext_run), .pin_o(ext));

  // On-chip oscillators, stopped unless selected; watchdog one always runs
  always @(negedge clk_i) begin
    ph <= ph + 1;
    rc <= rc_run && (ph % 6 < 3);
    lf <= lf_run && (ph % 10 < 5);
    wdt <= (ph % 8 < 4);
  end

  assign sel_pin = (src == SRC_EXT) ? ext : (src == SRC_LF) ? lf : rc;
  always @(posedge sel_pin) n_sel++;
  always @(posedge wdt) if (!rst_i && n_sel >= RST_START_CK) n_wl++;

  always @(posedge clk_i) begin
    cyc++;
    if (stk === 1'b1) n_sys++;
    if (ntk === 1'b1) n_nvm++;
    if (wtk === 1'b1) n_wtk++;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic do_reset(input logic [1:0] s, input logic [1:0] u, input logic d);
    @(negedge clk_i);
    rst_i = 1'b1;
    src = s;
    startup_delay_fuse = u;
    div8 = d;
    cal = {u[0], s, u, 3'h5};
    ext_run = (s == SRC_EXT);
    rc_run = (s == SRC_RC_LOW) || (s == SRC_RC_HIGH);
    lf_run = (s == SRC_LF);
    repeat (3) @(negedge clk_i);
    // Edges from here on reach the design's counter through its synchroniser
    n_sel = 0;
    @(negedge clk_i);
    chk(tval === cal[6:0], "trim reset load");
    chk(trd === {1'b0, cal[6:0]}, "trim bit 7");
    chk(psel === (d ? PRESC_DIV1_RST : PRESC_DIV8_RST), "prescaler reset");
    chk(rch === (s == SRC_RC_HIGH) && rel === 1'b0, "range flag");
    rst_i = 1'b0;
    n_wl = 0;
    n_nvm = 0;
    n_wtk = 0;
  endtask

  task automatic wait_rel();
    for (int i = 0; i < 3000 && rel !== 1'b1; i++) @(negedge clk_i);
    chk(rel === 1'b1, "no release");
  endtask

  task automatic t_startup();
    int w;
    for (int s = 0; s < 4; s++) begin
      for (int u = 0; u < 4; u++) begin
        do_reset(2'(s), 2'(u), u[0]);
        w = (u == 0) ? 0 : (u == 1) ? WS : WL;
        wait_rel();
        chk(n_sel >= RST_START_CK, "source count");
        chk(n_wl >= w && n_wl <= w + 1, "watchdog count");
        chk(cen === 1'b1 && fen === 1'b1 && pen === 1'b1 && aen === 1'b1, "enables");
        chk((n_nvm > 0) === (s == 1 || s == 2), "nvm tick");
        chk(n_wtk >= w, "watchdog tick");
      end
    end
    $display("done startup");
  endtask

  task automatic wr_trim(input logic [7:0] v);
    @(negedge clk_i);
    twr = 1'b1;
    twd = v;
    @(negedge clk_i);
    twr = 1'b0;
    chk(tval === v[6:0] && trd === {1'b0, v[6:0]}, "trim write");
  endtask

  task automatic count_sys(input logic wr, input logic [3:0] p, input int edges);
    if (wr) begin
      @(negedge clk_i);
      pwr = 1'b1;
      pwd = p;
      @(negedge clk_i);
      pwr = 1'b0;
    end
    chk(psel === p, "prescaler value");
    n_sel = 0;
    n_sys = 0;
    for (int i = 0; i < 4000 && n_sel < edges; i++) @(negedge clk_i);
    chk(n_sys >= (edges >> p) - 1 && n_sys <= (edges >> p) + 1, "tick rate");
  endtask

  task automatic t_pd();
    do_reset(SRC_LF, SUT_NONE, 1'b1);
    wait_rel();
    wake = 1'b1;
    @(negedge clk_i);
    wake = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(rel === 1'b1, "wake in run");
    pd = 1'b1;
    @(negedge clk_i);
    pd = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(rel === 1'b0 && cen === 1'b0 && aen === 1'b0, "power-down");
    irq = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(eid === 1'b1 && rel === 1'b0, "interrupt in power-down");
    irq = 1'b0;
    repeat (36) @(negedge clk_i);
    chk(rel === 1'b0, "stays down");
    n_sel = 0;
    wake = 1'b1;
    @(negedge clk_i);
    wake = 1'b0;
    wait_rel();
    chk(n_sel >= PD_START_CK && n_sel <= PD_START_CK + 1, "wake count");
    $display("done power-down");
  endtask

  task automatic t_gate();
    chalt = 1'b1;
    repeat (2) @(negedge clk_i);
    chk(cen === 1'b0 && fen === 1'b0 && pen === 1'b1 && aen === 1'b1, "core halt");
    phalt = 1'b1;
    irq = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(pen === 1'b0 && aen === 1'b1 && eid === 1'b1, "peripheral halt");
    irq = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(eid === 1'b0, "interrupt level");
    chalt = 1'b0;
    phalt = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(cen === 1'b1 && pen === 1'b1, "resume");
    $display("done gating");
  endtask

  initial begin
    t_startup();
    // Steps of at most 0x20 from 0x7D; no memory write runs meanwhile
    wr_trim(8'hFF);
    wr_trim(8'hE0);
    wr_trim(8'h40);
    wr_trim(8'h20);
    wr_trim(8'h00);
    $display("done trim");
    do_reset(SRC_RC_HIGH, SUT_NONE, FUSE_PROGRAMMED);
    wait_rel();
    count_sys(1'b0, PRESC_DIV8_RST, 32);
    count_sys(1'b1, 4'h0, 16);
    count_sys(1'b1, PRESC_MAX, 512);
    $display("done prescaler");
    t_pd();
    t_gate();
    print_verdict();
  end
endmodule // clock_source_startup_control_tb_top
